// *** hw/pswl_regs.vh ***
// Constants of the synthesizer serial word loader: register offsets,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name from the design files.
//
// Summary of operation
// - Transmit enabled when transmit select is low and receive select high.
// - Receive enabled when receive select is low and transmit select high.
// - Lock indicator high while synthesizer locked, low while unlocked; the code holds it low while the lock function bit is set.
// - Each serial clock rising edge shifts the data bit into 19 bits.
// - Load strobe after shifting copies the shift register into a latch.
// - Last shifted control bit picks reference or programmable latch.
// - Reference divider is 14 bits, range 3 through 16383.
// - Programmable divider is 11 bits, range 3 through 2047.
// - Swallow count is 7 bits, below the programmable divider value.
// - Prescaler ratio is either 64 or 128.
`ifndef PSWL_REGS_VH
`define PSWL_REGS_VH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define PSWL_ADDR_STATUS   8'h00
`define PSWL_ADDR_REFWORD  8'h04
`define PSWL_ADDR_PROGWORD 8'h08
`define PSWL_ADDR_ERROR    8'h0c
`define PSWL_ADDR_CTRL     8'h10
`define PSWL_ADDR_DIVTOTAL 8'h14

// ************************************************************
// Serial word layout, bit 0 is the last bit shifted in
// ************************************************************
`define PSWL_WORD_BITS     19
`define PSWL_BIT_TARGET    0
`define PSWL_BIT_PUMP      18
`define PSWL_BIT_LOCKFN    17
`define PSWL_BIT_PHASE     16
`define PSWL_BIT_PRESCALE  15
`define PSWL_REF_MSB       14
`define PSWL_REF_LSB       1
`define PSWL_PROG_MSB      18
`define PSWL_PROG_LSB      8
`define PSWL_SWAL_MSB      7
`define PSWL_SWAL_LSB      1
`define PSWL_DIV_MIN       3
`define PSWL_PRESCALE_LO   64
`define PSWL_PRESCALE_HI   128

// ************************************************************
// Control and error fields, reset values
// ************************************************************
`define PSWL_CTRL_LOAD_EN  0
`define PSWL_CTRL_RF_OFF   1
`define PSWL_CTRL_RESET    2'h1
`define PSWL_ERR_BAD_REF   0
`define PSWL_ERR_BAD_PROG  1
`define PSWL_ERR_TX_LOAD   2
`define PSWL_ERR_SHORT     3
`define PSWL_ERR_LONG      4
`define PSWL_ERR_BITS      5

// ************************************************************
// Timing
// ************************************************************
`define PSWL_CLK_NS        10
`define PSWL_PULSE_MIN_NS  100000
`define PSWL_PULSE_MAX_NS  15000000

`endif

// *** hw/pswl_sync.v ***
// Two-stage synchroniser for a group of pin inputs.
// Assumes asynchronous inputs and one destination clock.
`timescale 1ns/10ps
`default_nettype none
module pswl_sync #(
  parameter                WIDTH     = 1,
  parameter [WIDTH-1:0]    RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire [WIDTH-1:0]  async_in,
  output wire [WIDTH-1:0]  sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Only the second stage feeds logic; the first may be metastable
      reg stage1;
      reg stage2;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1 <= RESET_VAL[i];
          stage2 <= RESET_VAL[i];
        end else begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate
endmodule
`default_nettype wire

// *** hw/pswl_top.v ***
// Serial word loader of the synthesizer with transmit/receive select
// and lock indicator, plus an APB register view.
// Assumes pins arrive asynchronously and the serial clock is far slower
// than pclk, so its edges are found by sampling.
// Limitation: a serial clock phase shorter than one pclk period can be
// lost, and loads are refused while the control load enable is clear.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pswl_regs.vh"
module pswl_top #(
  parameter         WORD_BITS     = `PSWL_WORD_BITS,
  parameter integer PULSE_MIN_CYC =
    (`PSWL_PULSE_MIN_NS + `PSWL_CLK_NS - 1) / `PSWL_CLK_NS,
  parameter integer PULSE_MAX_CYC = `PSWL_PULSE_MAX_NS / `PSWL_CLK_NS,
  parameter         CNT_W         = 22
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        serial_clock,
  input  wire        serial_data,
  input  wire        load_strobe,
  input  wire        transmit_enable_n,
  input  wire        receive_enable_n,
  input  wire        tx_bitstream_in,
  input  wire        synth_locked,
  output reg         tx_enable,
  output reg         rx_enable,
  output reg         tx_mod_data,
  output reg         lock_indicator
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Every pin passes two flops; select pins reset high, their idle level,
  // so neither enable can blip on while reset is released.
  wire [6:0] pin_sync;

  pswl_sync #(
    .WIDTH     (7),
    .RESET_VAL (7'h18)
  ) u_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({synth_locked,
                tx_bitstream_in,
                receive_enable_n,
                transmit_enable_n,
                load_strobe,
                serial_data,
                serial_clock}),
    .sync_out (pin_sync)
  );

  wire s_clk    = pin_sync[0];
  wire s_data   = pin_sync[1];
  wire s_load   = pin_sync[2];
  wire s_tx_n   = pin_sync[3];
  wire s_rx_n   = pin_sync[4];
  wire s_txbit  = pin_sync[5];
  wire s_locked = pin_sync[6];

  // ************************************************************
  // Edge detection on synchronised pins
  // ************************************************************
  // Reset values equal the idle pin levels, so reset makes no false edge
  reg clk_prev;
  reg load_prev;
  reg txbit_prev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev   <= 1'b0;
      load_prev  <= 1'b0;
      txbit_prev <= 1'b0;
    end else begin
      clk_prev   <= s_clk;
      load_prev  <= s_load;
      txbit_prev <= s_txbit;
    end
  end

  wire clk_rise   = s_clk & ~clk_prev;
  wire load_rise  = s_load & ~load_prev;
  // Both levels of the transmit data are timed, so either edge counts
  wire txbit_edge = s_txbit ^ txbit_prev;

  // ************************************************************
  // Registers and helpers
  // ************************************************************
  reg [WORD_BITS-1:0] shift_word;
  reg [13:0]          ref_div;
  reg                 pump_sel;
  reg                 lock_fn;
  reg                 phase_sense;
  reg                 prescale_sel;
  reg [10:0]          prog_div;
  reg [6:0]           swallow;
  reg                 ref_loaded;
  reg                 prog_loaded;
  reg [1:0]           ctrl;
  reg [`PSWL_ERR_BITS-1:0] err;
  reg [CNT_W-1:0]     pulse_cnt;
  reg                 long_seen;

  // Divider words are checked on load only, before they reach a latch
  function ref_ok;
    input [WORD_BITS-1:0] w;
    begin
      ref_ok = (w[`PSWL_REF_MSB:`PSWL_REF_LSB] >= 14'd`PSWL_DIV_MIN);
    end
  endfunction

  // The swallow count must stay below the divider for the count to work
  function prog_ok;
    input [WORD_BITS-1:0] w;
    reg [10:0] n;
    begin
      n       = w[`PSWL_PROG_MSB:`PSWL_PROG_LSB];
      prog_ok = (n >= 11'd`PSWL_DIV_MIN) &&
                ({4'h0, w[`PSWL_SWAL_MSB:`PSWL_SWAL_LSB]} < n);
    end
  endfunction

  wire load_en   = ctrl[`PSWL_CTRL_LOAD_EN];
  wire rf_off    = ctrl[`PSWL_CTRL_RF_OFF];
  wire do_load   = load_rise & load_en;
  wire to_ref    = shift_word[`PSWL_BIT_TARGET];
  wire ref_good  = ref_ok(shift_word);
  wire prog_good = prog_ok(shift_word);

  // ************************************************************
  // Serial shift register and latches
  // ************************************************************
  // Word layout, bit 0 is the last bit in and picks the latch:
  //   reference:    pump, lock function, phase sense, prescaler, divider
  //   programmable: divider in 18..8, swallow count in 7..1
  // Bits beyond the word width simply fall off the top.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_word <= {WORD_BITS{1'b0}};
    end else if (clk_rise) begin
      shift_word <= {shift_word[WORD_BITS-2:0], s_data};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_div      <= 14'h0000;
      pump_sel     <= 1'b0;
      lock_fn      <= 1'b0;
      phase_sense  <= 1'b1;
      prescale_sel <= 1'b0;
      prog_div     <= 11'h000;
      swallow      <= 7'h00;
      ref_loaded   <= 1'b0;
      prog_loaded  <= 1'b0;
    end else if (do_load) begin
      // Out-of-range words are dropped so the old channel stays set
      // A load refused by the control bit is lost, not held for later
      if (to_ref && ref_good) begin
        ref_div      <= shift_word[`PSWL_REF_MSB:`PSWL_REF_LSB];
        pump_sel     <= shift_word[`PSWL_BIT_PUMP];
        lock_fn      <= shift_word[`PSWL_BIT_LOCKFN];
        phase_sense  <= shift_word[`PSWL_BIT_PHASE];
        prescale_sel <= shift_word[`PSWL_BIT_PRESCALE];
        ref_loaded   <= 1'b1;
      end else if (!to_ref && prog_good) begin
        prog_div    <= shift_word[`PSWL_PROG_MSB:`PSWL_PROG_LSB];
        swallow     <= shift_word[`PSWL_SWAL_MSB:`PSWL_SWAL_LSB];
        prog_loaded <= 1'b1;
      end
    end
  end

  // Total division number: prescaler times divider plus swallow
  // Shown to software only, as a check of what the host loaded
  wire [17:0] div_total = prescale_sel ?
    {prog_div, 7'h00} + {11'h000, swallow} :
    {1'b0, prog_div, 6'h00} + {11'h000, swallow};

  // ************************************************************
  // Transmit/receive select and lock output
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_enable      <= 1'b0;
      rx_enable      <= 1'b0;
      tx_mod_data    <= 1'b0;
      lock_indicator <= 1'b0;
    end else begin
      // Both selects low counts as neither, so the radio never keys up
      // while it still listens
      tx_enable      <= ~s_tx_n & s_rx_n & ~rf_off;
      rx_enable      <= ~s_rx_n & s_tx_n & ~rf_off;
      tx_mod_data    <= tx_enable & s_txbit;
      // The alternate pin function is not built; that setting reads low
      lock_indicator <= s_locked & ~lock_fn;
    end
  end

  // ************************************************************
  // Transmit pulse width monitor
  // ************************************************************
  // Pulses are only timed while transmitting; the first edge after
  // entering transmit is not judged, its start time is unknown.
  reg timing_valid;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt    <= {CNT_W{1'b0}};
      long_seen    <= 1'b0;
      timing_valid <= 1'b0;
    end else if (!tx_enable) begin
      pulse_cnt    <= {CNT_W{1'b0}};
      long_seen    <= 1'b0;
      timing_valid <= 1'b0;
    end else if (txbit_edge) begin
      pulse_cnt    <= {{(CNT_W-1){1'b0}}, 1'b1};
      long_seen    <= 1'b0;
      timing_valid <= 1'b1;
    end else begin
      // Saturate so a stuck level never wraps round into a short one
      if (pulse_cnt != {CNT_W{1'b1}}) begin
        pulse_cnt <= pulse_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (pulse_cnt == PULSE_MAX_CYC[CNT_W-1:0]) begin
        long_seen <= 1'b1;
      end
    end
  end

  // The long flag fires once per level, at the count that reaches the limit
  wire short_evt = tx_enable & txbit_edge & timing_valid &
                   (pulse_cnt < PULSE_MIN_CYC[CNT_W-1:0]);
  wire long_evt  = tx_enable & ~txbit_edge & ~long_seen &
                   (pulse_cnt == PULSE_MAX_CYC[CNT_W-1:0]);

  // ************************************************************
  // APB slave
  // ************************************************************
  wire apb_setup = psel & ~penable;
  wire apb_write = psel & penable & pready & pwrite;
  // Writes land at the access edge, when pready is already high
  wire wr_ctrl   = apb_write & (paddr == `PSWL_ADDR_CTRL);
  wire wr_err    = apb_write & (paddr == `PSWL_ADDR_ERROR);

  function addr_hit;
    input [7:0] a;
    begin
      addr_hit = (a == `PSWL_ADDR_STATUS)   ||
                 (a == `PSWL_ADDR_REFWORD)  ||
                 (a == `PSWL_ADDR_PROGWORD) ||
                 (a == `PSWL_ADDR_ERROR)    ||
                 (a == `PSWL_ADDR_CTRL)     ||
                 (a == `PSWL_ADDR_DIVTOTAL);
    end
  endfunction

  reg [31:0] next_prdata;

  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `PSWL_ADDR_STATUS:
        next_prdata = {27'h0, prog_loaded, ref_loaded,
                       rx_enable, tx_enable, lock_indicator};
      `PSWL_ADDR_REFWORD:
        next_prdata = {14'h0, pump_sel, lock_fn, phase_sense,
                       prescale_sel, ref_div};
      `PSWL_ADDR_PROGWORD:
        next_prdata = {13'h0, prog_div, 1'b0, swallow};
      `PSWL_ADDR_ERROR:
        next_prdata = {{(32-`PSWL_ERR_BITS){1'b0}}, err};
      `PSWL_ADDR_CTRL:
        next_prdata = {30'h0, ctrl};
      `PSWL_ADDR_DIVTOTAL:
        next_prdata = {14'h0, div_total};
      default:
        next_prdata = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave: answer is registered in the setup cycle
  // Read data is frozen at setup, so a flag that changes in the access
  // cycle shows on the next read instead.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= ~addr_hit(paddr);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PSWL_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[1:0];
    end
  end

  // ************************************************************
  // Sticky error flags, write one to clear, a new event wins
  // ************************************************************
  wire [`PSWL_ERR_BITS-1:0] err_set;
  wire [`PSWL_ERR_BITS-1:0] err_clr;

  assign err_set[`PSWL_ERR_BAD_REF]  = do_load & to_ref & ~ref_good;
  assign err_set[`PSWL_ERR_BAD_PROG] = do_load & ~to_ref & ~prog_good;
  // Loading a channel while the transmitter runs causes stray emission
  assign err_set[`PSWL_ERR_TX_LOAD]  = do_load & tx_enable;
  assign err_set[`PSWL_ERR_SHORT]    = short_evt;
  assign err_set[`PSWL_ERR_LONG]     = long_evt;
  assign err_clr = wr_err ?
                   pwdata[`PSWL_ERR_BITS-1:0] :
                   {`PSWL_ERR_BITS{1'b0}};

  // Set wins over clear, so an event in the clearing cycle is kept

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= {`PSWL_ERR_BITS{1'b0}};
    end else begin
      err <= (err & ~err_clr) | err_set;
    end
  end

endmodule
`default_nettype wire

// *** testbench/pswl_chk_sva.sv ***
// Checker for the serial word loader: select pins, lock and APB answer.
// Assumes it is bound to pswl_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "pswl_regs.vh"
module pswl_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic transmit_enable_n,
  input wire logic receive_enable_n,
  input wire logic synth_locked,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic tx_mod_data,
  input wire logic lock_indicator
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mirror of the force-off control bit, taken at the write's access edge
  logic rf_m;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_m <= 1'b0;
    end else if (psel && penable && pready && pwrite &&
                 paddr == `PSWL_ADDR_CTRL) begin
      rf_m <= pwdata[`PSWL_CTRL_RF_OFF];
    end
  end
  // ********************************
  // Properties
  // ********************************
  // Eight stable samples cover two sync stages and the output flop
  property p_tx_on;
    (!transmit_enable_n && receive_enable_n && !rf_m) [*8] |-> tx_enable;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx not on");
  property p_tx_off;
    transmit_enable_n [*8] |-> !tx_enable;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx not off");
  property p_rx_on;
    (!receive_enable_n && transmit_enable_n && !rf_m) [*8] |-> rx_enable;
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("rx not on");
  property p_rx_off;
    receive_enable_n [*8] |-> !rx_enable;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx not off");
  property p_excl;
    !(tx_enable && rx_enable);
  endproperty
  a_excl: assert property (p_excl) else $error("tx and rx on");
  property p_rf_off;
    rf_m [*2] |-> !tx_enable && !rx_enable;
  endproperty
  a_rf_off: assert property (p_rf_off) else $error("rf not off");
  property p_lock_hi;
    synth_locked [*8] |-> lock_indicator;
  endproperty
  a_lock_hi: assert property (p_lock_hi) else $error("lock low");
  property p_lock_lo;
    !synth_locked [*8] |-> !lock_indicator;
  endproperty
  a_lock_lo: assert property (p_lock_lo) else $error("lock high");
  property p_mod;
    tx_mod_data |-> $past(tx_enable);
  endproperty
  a_mod: assert property (p_mod) else $error("data while not tx");
  property p_ready;
    psel && !penable |=> pready && penable;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule
bind pswl_top pswl_chk chk_u (.pclk, .presetn, .psel, .penable, .pready,
  .pwrite, .paddr, .pwdata,
  .pslverr, .transmit_enable_n, .receive_enable_n, .synth_locked,
  .tx_enable, .rx_enable, .tx_mod_data, .lock_indicator);
`default_nettype wire

// *** testbench/pswl_host_model.sv ***
// Host model driving the synthesizer serial lines.
// Assumes pclk at 100 MHz; the serial clock idles low between frames.
`timescale 1ns/10ps
`default_nettype none
module pswl_host_model (
  input  wire logic pclk,
  output var  logic sclk,
  output var  logic sdata,
  output var  logic le
);
  // Half period in pclk cycles: 8 gives 80 ns, 16 a slow host
  int half = 8;
  initial begin
    sclk = 1'h0;
    sdata = 1'h0;
    le = 1'h0;
  end
  // ********************************
  // Frame
  // ********************************
  task automatic send(input logic [20:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge pclk);
      sdata <= w[i];
      repeat (half) @(posedge pclk);
      sclk <= 1'h1;
      repeat (half) @(posedge pclk);
      sclk <= 1'h0;
    end
    repeat (half) @(posedge pclk);
    le <= 1'h1;
    repeat (half) @(posedge pclk);
    le <= 1'h0;
    // Released line flips so a stale bit can never pass as data
    sdata <= ~w[0];
  endtask
endmodule
`default_nettype wire

// *** testbench/pswl_top_test.sv ***
// Bench for the serial word loader: pins, serial loads and registers.
// Assumes the host model drives the serial lines and APB is zero wait.
`timescale 1ns/10ps
`default_nettype none
`include "pswl_regs.vh"
module pswl_top_test;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic        txn = 1'h1;
  logic        rxn = 1'h1;
  logic        lk = 1'h0;
  logic        txd = 1'h0;
  logic [31:0] q;
  logic        er;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;
  // Host channel arithmetic: 458.000 MHz channel, 12.5 kHz comparison
  localparam int FCH_KHZ  = 458000;
  localparam int FOFF_KHZ = 21700;
  localparam int FCMP_HZ  = 12500;
  localparam int REF_R    = 21250000 / FCMP_HZ;
  localparam int DIV_N    = (FCH_KHZ - FOFF_KHZ) * 1000 / FCMP_HZ;
  localparam int PROG_N   = DIV_N / `PSWL_PRESCALE_LO;
  localparam int SWAL_A   = DIV_N % `PSWL_PRESCALE_LO;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, sclk, sdata, le;
  wire logic   tx_enable, rx_enable, tx_mod_data, lock_indicator;
  // Rows: tx_n, rx_n, locked, then expected tx, rx, lock
  logic [5:0]  rows [5] = '{6'h1d, 6'h22, 6'h09, 6'h30, 6'h2b};

  always #5 pclk = ~pclk;

  pswl_top #(.PULSE_MIN_CYC(20), .PULSE_MAX_CYC(100)) dut_u (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_clock(sclk), .serial_data(sdata), .load_strobe(le),
    .transmit_enable_n(txn), .receive_enable_n(rxn), .tx_bitstream_in(txd),
    .synth_locked(lk), .tx_enable, .rx_enable, .tx_mod_data,
    .lock_indicator);
  pswl_host_model host_u (.pclk, .sclk, .sdata, .le);

  // ********************************
  // Tasks
  // ********************************
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic ld(input logic [20:0] w, input int n);
    host_u.send(w, n);
    repeat (10) @(posedge pclk);
  endtask
  task automatic pulse(input int hi);
    txd <= 1'h1;
    repeat (hi) @(posedge pclk);
    if (hi > 10) chk(tx_mod_data, 32'h1);
    txd <= 1'h0;
    repeat (50) @(posedge pclk);
  endtask
  function automatic logic [18:0] rw(logic p, logic [13:0] r);
    return {3'h1, p, r, 1'h1};
  endfunction
  function automatic logic [18:0] pw(logic [10:0] n, logic [6:0] a);
    return {n, a, 1'h0};
  endfunction

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail++;
      finish_test();
    end
  end

  // ********************************
  // Sequence
  // ********************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    rd(`PSWL_ADDR_CTRL, 32'h1);
    rd(`PSWL_ADDR_REFWORD, 32'h8000);
    foreach (rows[i]) begin
      {txn, rxn, lk} <= rows[i][5:3];
      repeat (10) @(posedge pclk);
      chk({tx_enable, rx_enable, lock_indicator}, rows[i][2:0]);
      apb(1'h0, `PSWL_ADDR_STATUS, 32'h0);
      chk(q[2:0], {rows[i][1], rows[i][2], rows[i][0]});
    end
    ld(rw(1'h0, REF_R[13:0]), 19);
    rd(`PSWL_ADDR_REFWORD, 32'h86a4);
    chk(lock_indicator, 32'h1);
    host_u.half = 16;
    ld({2'h3, pw(PROG_N[10:0], SWAL_A[6:0])}, 21);
    host_u.half = 8;
    rd(`PSWL_ADDR_PROGWORD, 32'h22118);
    rd(`PSWL_ADDR_DIVTOTAL, 32'h8858);
    ld(rw(1'h1, 14'h3), 19);
    rd(`PSWL_ADDR_REFWORD, 32'hc003);
    rd(`PSWL_ADDR_DIVTOTAL, 32'h11098);
    ld(rw(1'h0, 14'h2), 19);
    rd(`PSWL_ADDR_ERROR, 32'h1);
    rd(`PSWL_ADDR_REFWORD, 32'hc003);
    ld(pw(11'h5, 7'h5), 19);
    rd(`PSWL_ADDR_ERROR, 32'h3);
    ld(pw(11'h3, 7'h2), 19);
    rd(`PSWL_ADDR_PROGWORD, 32'h302);
    apb(1'h1, `PSWL_ADDR_ERROR, 32'h3);
    rd(`PSWL_ADDR_ERROR, 32'h0);
    apb(1'h1, `PSWL_ADDR_CTRL, 32'h0);
    ld(pw(11'h7ff, 7'h0), 19);
    rd(`PSWL_ADDR_PROGWORD, 32'h302);
    apb(1'h1, `PSWL_ADDR_CTRL, 32'h1);
    ld(pw(11'h7ff, 7'h0), 19);
    rd(`PSWL_ADDR_PROGWORD, 32'h7ff00);
    apb(1'h1, `PSWL_ADDR_REFWORD, 32'h0);
    rd(`PSWL_ADDR_REFWORD, 32'hc003);
    rd(8'h20, 32'h0);
    chk(er, 32'h1);
    {txn, rxn} <= 2'h1;
    repeat (10) @(posedge pclk);
    apb(1'h1, `PSWL_ADDR_CTRL, 32'h3);
    repeat (5) @(posedge pclk);
    chk({tx_enable, rx_enable}, 32'h0);
    apb(1'h1, `PSWL_ADDR_CTRL, 32'h1);
    repeat (10) @(posedge pclk);
    chk(tx_enable, 32'h1);
    pulse(50);
    pulse(5);
    pulse(150);
    ld(pw(PROG_N[10:0], SWAL_A[6:0]), 19);
    rd(`PSWL_ADDR_ERROR, 32'h1c);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(`PSWL_ADDR_ERROR, 32'h0);
    rd(`PSWL_ADDR_PROGWORD, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
